// ### pmi_pkg.sv
// Constants and types shared by the port pattern-match interrupt block
`default_nettype none
package pmi_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PMI_PORT_W = 8;
    localparam int PMI_ADDR_W = 4;
    localparam int PMI_DATA_W = 8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] PMI_OFS_MATCH_CONTROL = 4'h0;
    localparam logic [3:0] PMI_OFS_PIN_SELECT_MASK = 4'h1;
    localparam logic [3:0] PMI_OFS_COMPARE_PATTERN = 4'h2;
    localparam logic [3:0] PMI_OFS_PORT_STATUS = 4'h3;

    // ------------------------------------------------------------
    // Field positions in match_control
    // ------------------------------------------------------------
    localparam int PMI_BIT_MATCH_FLAG = 0;
    localparam int PMI_BIT_POLARITY = 1;
    localparam int PMI_BIT_IRQ_EN = 2;
    localparam int PMI_BIT_ACTIVE = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PMI_RST_MASK = 8'h00;
    localparam logic [7:0] PMI_RST_PATTERN = 8'hFF;
    localparam logic PMI_RST_POLARITY = 1'b0;
    localparam logic PMI_RST_IRQ_EN = 1'b0;
    localparam logic [7:0] PMI_RST_PORT = 8'hFF;
    localparam logic [7:0] PMI_RST_RDATA = 8'h00;

    // ------------------------------------------------------------
    // Timing: condition must persist more than this many core clocks
    // ------------------------------------------------------------
    localparam int PMI_HOLD_CORE_CLOCK = 6;
    localparam logic [3:0] PMI_HOLD_CNT = 4'(PMI_HOLD_CORE_CLOCK);
    localparam logic [3:0] PMI_CNT_ZERO = 4'h0;
    localparam logic [3:0] PMI_CNT_ONE = 4'h1;

    // ------------------------------------------------------------
    // Qualifier states, Gray along idle -> qualify -> matched
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PMI_ST_IDLE = 2'b00,
        PMI_ST_QUAL = 2'b01,
        PMI_ST_MATCHED = 2'b11
    } pmi_state_t;

endpackage
`default_nettype wire

// ### pmi_port_match.sv
// Port pattern-match interrupt: register file, pin synchroniser, qualifier and flag
//
// How it works
// - Only pins whose bit is set in pin_select_mask take part; unmasked pins never trigger a match.
// - The settled port value is compared every cycle against the software-written compare_pattern.
// - compare_polarity_select picks equal (0) or not-equal (1) as the meaning of a match.
// - match_flag in match_control is set when the condition holds while active; an interrupt is asked only if enabled.
// - Pattern all ones with not-equal selected flags any enabled pin that leaves high, as a keypad would.
// - An enabled match raises a wake request that brings the core out of idle and power-down.
// - The flag is set only once the condition has persisted for more than 6 core clocks; sources must hold that long.
`timescale 1ns/1ns
`default_nettype none
module pmi_port_match
    import pmi_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [PMI_ADDR_W-1:0] addr,
    input wire logic [PMI_DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [PMI_DATA_W-1:0] rd_data,
    input wire logic [PMI_PORT_W-1:0] port_pin_in,
    input wire logic idle_mode,
    input wire logic power_down_mode,
    output logic match_irq,
    output logic wake_req
);

    // ------------------------------------------------------------
    // Decode helper
    // ------------------------------------------------------------
    function automatic logic reg_hit(input logic [PMI_ADDR_W-1:0] a, input logic [3:0] ofs);
        reg_hit = (a == ofs);
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [PMI_PORT_W-1:0] sync1_r;
    logic [PMI_PORT_W-1:0] sync2_r;
    logic [PMI_PORT_W-1:0] sync3_r;
    logic [PMI_PORT_W-1:0] port_r;
    logic [PMI_PORT_W-1:0] port_nxt;
    logic [PMI_PORT_W-1:0] pin_select_mask_r;
    logic [PMI_PORT_W-1:0] compare_pattern_r;
    logic compare_polarity_select_r;
    logic irq_en_r;
    logic match_flag_r;
    logic match_flag_nxt;
    logic [3:0] hold_cnt_r;
    logic [3:0] hold_cnt_nxt;
    pmi_state_t state_r;
    pmi_state_t state_nxt;
    logic [PMI_PORT_W-1:0] diff_bits;
    logic any_diff;
    logic fn_active;
    logic cond_now;
    logic set_flag;
    logic clr_flag;
    logic wr_ctrl;
    logic [PMI_DATA_W-1:0] rd_data_r;
    logic [PMI_DATA_W-1:0] rd_data_nxt;
    logic match_irq_r;
    logic wake_req_r;

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    // Three stages per pin; a new level is accepted only when stages two and
    // three agree, which filters a one-cycle glitch from the pins.
    genvar gi;
    generate
        for (gi = 0; gi < PMI_PORT_W; gi++)
        begin : g_pin
            always_ff @(posedge clk)
            begin
                if (srst)
                begin
                    sync1_r[gi] <= PMI_RST_PORT[gi];
                    sync2_r[gi] <= PMI_RST_PORT[gi];
                    sync3_r[gi] <= PMI_RST_PORT[gi];
                end
                else
                begin
                    sync1_r[gi] <= port_pin_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                end
            end

            always_comb
            begin
                port_nxt[gi] = port_r[gi];
                if (sync2_r[gi] == sync3_r[gi])
                begin
                    port_nxt[gi] = sync3_r[gi];
                end
            end

            // Masked pins only; a pin outside the mask can never differ
            assign diff_bits[gi] = pin_select_mask_r[gi] & (port_r[gi] ^ compare_pattern_r[gi]);
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            port_r <= PMI_RST_PORT;
        end
        else
        begin
            port_r <= port_nxt;
        end
    end

    // ------------------------------------------------------------
    // Compare
    // ------------------------------------------------------------
    // With pattern FF and not-equal, any enabled pin pulled low differs
    assign any_diff = |diff_bits;
    assign fn_active = |pin_select_mask_r;
    assign cond_now = fn_active & (compare_polarity_select_r ? any_diff : ~any_diff);

    // ------------------------------------------------------------
    // Persistence qualifier
    // ------------------------------------------------------------
    // Counts consecutive cycles of the condition; a single dropout restarts it.
    always_comb
    begin
        state_nxt = state_r;
        hold_cnt_nxt = hold_cnt_r;
        case (state_r)
            PMI_ST_IDLE:
            begin
                hold_cnt_nxt = PMI_CNT_ZERO;
                if (cond_now)
                begin
                    state_nxt = PMI_ST_QUAL;
                    hold_cnt_nxt = PMI_CNT_ONE;
                end
            end
            PMI_ST_QUAL:
            begin
                if (!cond_now)
                begin
                    state_nxt = PMI_ST_IDLE;
                    hold_cnt_nxt = PMI_CNT_ZERO;
                end
                else if (hold_cnt_r == PMI_HOLD_CNT)
                begin
                    state_nxt = PMI_ST_MATCHED;
                end
                else
                begin
                    hold_cnt_nxt = hold_cnt_r + PMI_CNT_ONE;
                end
            end
            PMI_ST_MATCHED:
            begin
                if (!cond_now)
                begin
                    state_nxt = PMI_ST_IDLE;
                    hold_cnt_nxt = PMI_CNT_ZERO;
                end
            end
            default:
            begin
                state_nxt = PMI_ST_IDLE;
                hold_cnt_nxt = PMI_CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_r <= PMI_ST_IDLE;
            hold_cnt_r <= PMI_CNT_ZERO;
        end
        else
        begin
            state_r <= state_nxt;
            hold_cnt_r <= hold_cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Match flag
    // ------------------------------------------------------------
    // Level behaviour: while the pattern is still held the flag is set again,
    // so clearing it only sticks once the pins have moved away.
    assign set_flag = (state_r == PMI_ST_MATCHED);
    assign wr_ctrl = wr_en & reg_hit(addr, PMI_OFS_MATCH_CONTROL);
    assign clr_flag = wr_ctrl & ~wr_data[PMI_BIT_MATCH_FLAG];

    always_comb
    begin
        match_flag_nxt = match_flag_r;
        if (clr_flag)
        begin
            match_flag_nxt = 1'b0;
        end
        if (set_flag)
        begin
            match_flag_nxt = 1'b1; // Set wins over a clear in the same cycle
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            match_flag_r <= 1'b0;
        end
        else
        begin
            match_flag_r <= match_flag_nxt;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            compare_polarity_select_r <= PMI_RST_POLARITY;
            irq_en_r <= PMI_RST_IRQ_EN;
        end
        else if (wr_ctrl)
        begin
            compare_polarity_select_r <= wr_data[PMI_BIT_POLARITY];
            irq_en_r <= wr_data[PMI_BIT_IRQ_EN];
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pin_select_mask_r <= PMI_RST_MASK;
        end
        else if (wr_en && reg_hit(addr, PMI_OFS_PIN_SELECT_MASK))
        begin
            pin_select_mask_r <= wr_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            compare_pattern_r <= PMI_RST_PATTERN;
        end
        else if (wr_en && reg_hit(addr, PMI_OFS_COMPARE_PATTERN))
        begin
            compare_pattern_r <= wr_data;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Unmapped offsets read as zero; data stands one cycle after the strobe only
    always_comb
    begin
        rd_data_nxt = PMI_RST_RDATA;
        if (rd_en)
        begin
            if (reg_hit(addr, PMI_OFS_MATCH_CONTROL))
            begin
                rd_data_nxt[PMI_BIT_MATCH_FLAG] = match_flag_r;
                rd_data_nxt[PMI_BIT_POLARITY] = compare_polarity_select_r;
                rd_data_nxt[PMI_BIT_IRQ_EN] = irq_en_r;
                rd_data_nxt[PMI_BIT_ACTIVE] = fn_active;
            end
            else if (reg_hit(addr, PMI_OFS_PIN_SELECT_MASK))
            begin
                rd_data_nxt = pin_select_mask_r;
            end
            else if (reg_hit(addr, PMI_OFS_COMPARE_PATTERN))
            begin
                rd_data_nxt = compare_pattern_r;
            end
            else if (reg_hit(addr, PMI_OFS_PORT_STATUS))
            begin
                rd_data_nxt = port_r;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rd_data_r <= PMI_RST_RDATA;
        end
        else
        begin
            rd_data_r <= rd_data_nxt;
        end
    end

    // ------------------------------------------------------------
    // Interrupt and wake
    // ------------------------------------------------------------
    // Wake is asked only while the core is idle or powered down; an awake core
    // sees the same event on match_irq alone. Both follow the next flag value,
    // so they rise on the edge that sets the flag.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            match_irq_r <= 1'b0;
            wake_req_r <= 1'b0;
        end
        else
        begin
            match_irq_r <= match_flag_nxt & irq_en_r;
            wake_req_r <= match_flag_nxt & irq_en_r & (idle_mode | power_down_mode);
        end
    end

    assign rd_data = rd_data_r;
    assign match_irq = match_irq_r;
    assign wake_req = wake_req_r;

endmodule
`default_nettype wire

// ### pmi_port_match_sva.sv
// Checker for the port pattern-match block
`timescale 1ns/1ns
`default_nettype none
module pmi_port_match_sva
    import pmi_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] port_pin_in,
    input wire logic idle_mode,
    input wire logic power_down_mode,
    input wire logic match_irq,
    input wire logic wake_req
);
    // ----
    // Shadow of the settings and a count of raw match cycles
    // ----
    logic [7:0] mask_r;
    logic [7:0] pat_r;
    logic pol_r;
    logic en_r;
    logic [3:0] cnt_r;
    logic [3:0] recent_r;
    logic cond;
    assign cond = (mask_r != 8'h00) && ((((port_pin_in ^ pat_r) & mask_r) != 8'h00) == pol_r);
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mask_r <= 8'h00;
            pat_r <= 8'hFF;
            pol_r <= 1'b0;
            en_r <= 1'b0;
        end
        else if (wr_en)
        begin
            if (addr == PMI_OFS_PIN_SELECT_MASK)
                mask_r <= wr_data;
            if (addr == PMI_OFS_COMPARE_PATTERN)
                pat_r <= wr_data;
            if (addr == PMI_OFS_MATCH_CONTROL)
                {en_r, pol_r} <= wr_data[2:1];
        end
    end
    // Raw pins lead the synchroniser, so the bounds below leave a margin
    always_ff @(posedge clk)
    begin
        if (srst || !cond)
            cnt_r <= 4'h0;
        else if (cnt_r != 4'hF)
            cnt_r <= cnt_r + 4'h1;
    end
    // Cycles since the raw condition last stood for seven samples in a row;
    // the flag may rise after the raw pins have already moved on
    always_ff @(posedge clk)
    begin
        if (srst)
            recent_r <= 4'hF;
        else if (cond && cnt_r >= 4'h6)
            recent_r <= 4'h0;
        else if (recent_r != 4'hF)
            recent_r <= recent_r + 4'h1;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    a_rd_idle_zero: assert property (!$past(rd_en) |-> rd_data == 8'h00)
        else $error("read data not idle");
    a_rd_mask_val: assert property ($past(rd_en && addr == PMI_OFS_PIN_SELECT_MASK) |-> rd_data == $past(mask_r))
        else $error("mask readback wrong");
    a_rd_pat_val: assert property ($past(rd_en && addr == PMI_OFS_COMPARE_PATTERN) |-> rd_data == $past(pat_r))
        else $error("pattern readback wrong");
    a_rd_ctrl_bits: assert property ($past(rd_en && addr == PMI_OFS_MATCH_CONTROL) |->
        rd_data[3:1] == $past({mask_r != 8'h00, en_r, pol_r})) else $error("control readback wrong");
    a_rd_unmapped_zero: assert property ($past(rd_en && addr > PMI_OFS_PORT_STATUS) |-> rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_irq_gated: assert property (!en_r && !$past(en_r) |-> !match_irq)
        else $error("irq while disabled");
    a_wake_mode: assert property (wake_req |-> $past(idle_mode || power_down_mode))
        else $error("wake outside low power");
    a_flag_sticky: assert property ($fell(match_irq) |-> $past(wr_en) || $past(wr_en, 2))
        else $error("flag dropped without write");
    a_hold_first: assert property ($rose(match_irq) && !$past(wr_en) && !$past(wr_en, 2) |-> recent_r <= 4'h8)
        else $error("flag set too early");
    a_match_within: assert property (en_r && cnt_r == 4'hD && !$past(wr_en) |-> match_irq)
        else $error("match not flagged");
endmodule
bind pmi_port_match pmi_port_match_sva pmi_port_match_sva_i (.clk(clk), .srst(srst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .port_pin_in(port_pin_in),
    .idle_mode(idle_mode), .power_down_mode(power_down_mode), .match_irq(match_irq), .wake_req(wake_req));
`default_nettype wire

// ### pmi_keypad.sv
// Keypad and parallel bus model on the port pins
`timescale 1ns/1ns
`default_nettype none
module pmi_keypad
(
    input wire logic clk,
    input wire logic [7:0] press,
    input wire logic bus_en,
    input wire logic [7:0] bus_val,
    output logic [7:0] pins
);
    // Released keys read high through pull-ups
    // Levels hold as long as asked; a short hold stands for a bounce
    always_ff @(posedge clk)
    begin
        pins <= bus_en ? bus_val : ~press;
    end
endmodule
`default_nettype wire

// ### pmi_port_match_tb_top.sv
// Bench for the port pattern-match block
`timescale 1ns/1ns
`default_nettype none
module pmi_port_match_tb_top;
    import pmi_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] rd_data;
    logic [7:0] pins;
    logic idle_mode = 1'b0;
    logic power_down_mode = 1'b0;
    logic match_irq;
    logic wake_req;
    logic [7:0] press = 8'h00;
    logic bus_en = 1'b0;
    logic [7:0] bus_val = 8'hFF;
    logic [7:0] m;
    logic [7:0] p;
    logic [7:0] v;
    logic [7:0] d;
    logic s;
    logic e;
    int failures = 0;
    int checks = 0;
    always #50 clk = ~clk;
    pmi_port_match pmi_port_match_i (.clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .port_pin_in(pins), .idle_mode(idle_mode),
        .power_down_mode(power_down_mode), .match_irq(match_irq), .wake_req(wake_req));
    pmi_keypad pmi_keypad_i (.clk(clk), .press(press), .bus_en(bus_en), .bus_val(bus_val), .pins(pins));
    // ----
    // Helpers
    // ----
    function automatic logic exp_match(logic [7:0] pv, logic [7:0] mk, logic [7:0] pt, logic pl);
        return (mk != 8'h00) && ((((pv ^ pt) & mk) != 8'h00) == pl);
    endfunction
    task automatic chk(logic [7:0] seen, logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] x);
        @(posedge clk);
        addr <= a;
        wr_data <= x;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, output logic [7:0] x);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
        x = rd_data;
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ----
    // Tests
    // ----
    initial
    begin
        void'($urandom(32'hBA90FA3D));
        cyc(10);
        srst <= 1'b0;
        rd(PMI_OFS_MATCH_CONTROL, d);
        chk(d, 8'h00);
        rd(PMI_OFS_PIN_SELECT_MASK, d);
        chk(d, 8'h00);
        rd(PMI_OFS_COMPARE_PATTERN, d);
        chk(d, 8'hFF);
        rd(4'h9, d);
        chk(d, 8'h00);
        wr(PMI_OFS_PIN_SELECT_MASK, 8'h01);
        wr(PMI_OFS_MATCH_CONTROL, 8'h06);
        press <= 8'h01;
        cyc(6);
        press <= 8'h00;
        cyc(14);
        chk({7'h00, match_irq}, 8'h00);
        press <= 8'h02;
        cyc(20);
        chk({7'h00, match_irq}, 8'h00);
        press <= 8'h01;
        cyc(16);
        chk({7'h00, match_irq}, 8'h01);
        idle_mode <= 1'b1;
        cyc(2);
        chk({7'h00, wake_req}, 8'h01);
        idle_mode <= 1'b0;
        power_down_mode <= 1'b1;
        press <= 8'h00;
        cyc(3);
        chk({7'h00, wake_req}, 8'h01);
        power_down_mode <= 1'b0;
        cyc(10);
        chk({7'h00, match_irq}, 8'h01);
        wr(PMI_OFS_MATCH_CONTROL, 8'h06);
        cyc(2);
        chk({7'h00, match_irq}, 8'h00);
        rd(PMI_OFS_MATCH_CONTROL, d);
        chk(d, 8'h0E);
        wr(PMI_OFS_MATCH_CONTROL, 8'h02);
        press <= 8'h01;
        cyc(16);
        chk({7'h00, match_irq}, 8'h00);
        rd(PMI_OFS_MATCH_CONTROL, d);
        chk(d, 8'h0B);
        press <= 8'h00;
        bus_en <= 1'b1;
        // Mask goes to zero first so that half-written settings never qualify
        for (int i = 0; i < 24; i++)
        begin
            m = (i == 2) ? 8'h00 : 8'($urandom());
            p = 8'($urandom());
            s = 1'($urandom());
            v = i[0] ? 8'($urandom()) : ((p & m) | (~m & 8'($urandom())));
            e = exp_match(v, m, p, s);
            wr(PMI_OFS_PIN_SELECT_MASK, 8'h00);
            bus_val <= v;
            idle_mode <= 1'($urandom());
            cyc(5);
            wr(PMI_OFS_COMPARE_PATTERN, p);
            wr(PMI_OFS_MATCH_CONTROL, {5'h00, 1'b1, s, 1'b0});
            wr(PMI_OFS_PIN_SELECT_MASK, m);
            cyc(14);
            rd(PMI_OFS_PORT_STATUS, d);
            chk(d, v);
            rd(PMI_OFS_MATCH_CONTROL, d);
            chk(d & 8'h01, {7'h00, e});
            chk({7'h00, wake_req}, {7'h00, e & idle_mode});
        end
        stop_test();
    end
    initial
    begin
        #3000000;
        failures++;
        stop_test();
    end
endmodule
`default_nettype wire
